//--- hw/dhb_pkg.sv
// timing constants, gate encodings and the bridge state enumeration
// assumes a single 10 MHz clock shared by every design file
package dhb_pkg;

  // clock and timing figures
  localparam int CLK_HZ          = 10000000;
  localparam int PWM_HZ          = 50000;
  localparam int BLANK_NS        = 3750;
  localparam int DEAD_NS         = 200;
  localparam int OCP_NS          = 3000;
  localparam int PWM_CYCLES      = CLK_HZ / PWM_HZ;
  localparam int BLANK_CYCLES    = (BLANK_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int DEAD_CYCLES     = (DEAD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int OCP_CYCLES      = (OCP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CNT_W           = 8;
  localparam int SCALE_W         = 2;
  localparam int LEVEL_W         = 7;

  // current scale codes and reference percentages
  localparam logic [1:0] SCALE_FULL = 2'h0;
  localparam logic [1:0] SCALE_71   = 2'h1;
  localparam logic [1:0] SCALE_38   = 2'h2;
  localparam logic [1:0] SCALE_OFF  = 2'h3;
  localparam logic [6:0] LEVEL_FULL = 7'h64;
  localparam logic [6:0] LEVEL_71   = 7'h47;
  localparam logic [6:0] LEVEL_38   = 7'h26;
  localparam logic [6:0] LEVEL_ZERO = 7'h00;

  // gate word: {a high, a low, b high, b low}
  localparam logic [3:0] GATE_OFF   = 4'h0;
  localparam logic [3:0] GATE_AFWD  = 4'h9;
  localparam logic [3:0] GATE_BFWD  = 4'h6;
  localparam logic [3:0] GATE_BRAKE = 4'h5;

  typedef enum logic [2:0] {
    DHB_IDLE  = 3'b000,
    DHB_DRIVE = 3'b001,
    DHB_FAST  = 3'b010,
    DHB_SLOW  = 3'b011,
    DHB_BRAKE = 3'b100,
    DHB_COAST = 3'b101,
    DHB_OCP   = 3'b110
  } dhb_state_t;

endpackage : dhb_pkg

//--- hw/dhb_bridge.sv
// one h-bridge: chopping, decay, blanking, dead-time and latched overcurrent
// assumes synchronous inputs, a pwm start pulse and a global run gate
module dhb_bridge (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // control from the top
  input  wire logic       run,
  input  wire logic       pwmStart,
  input  wire logic       decayFast,
  input  wire logic       directionIn,
  input  wire logic       bridgeEnableIn,
  input  wire logic [1:0] currentScale,
  // analog indications
  input  wire logic       chopTrip,
  input  wire logic       currentZero,
  input  wire logic       limitActive,
  // outputs
  output logic [3:0]      gateDrive,
  output logic [6:0]      refLevel,
  output logic            outAOe,
  output logic            outBOe,
  output logic            outA,
  output logic            outB,
  output logic            ocpLatched
);

  typedef struct packed {
    dhb_pkg::dhb_state_t      state;
    logic [dhb_pkg::CNT_W-1:0] blankCnt;
    logic [dhb_pkg::CNT_W-1:0] deadCnt;
    logic [dhb_pkg::CNT_W-1:0] ocpCnt;
    logic [3:0]                gate;
    logic [3:0]                lastGate;
    logic                      overcurrent_shutdown;
  } dhb_br_t;

  dhb_br_t br_reg;
  dhb_br_t br_next;
  logic [3:0] want;
  logic       driveOk;

  ////////////////////////////////////////////////////////////////////////////
  // next state and wanted gate pattern
  always_comb begin
    br_next = br_reg;
    want    = dhb_pkg::GATE_OFF;
    driveOk = bridgeEnableIn && (currentScale != dhb_pkg::SCALE_OFF);
    // overcurrent qualification ignores the chopping path entirely
    if (limitActive && br_reg.ocpCnt < dhb_pkg::CNT_W'(dhb_pkg::OCP_CYCLES))
      br_next.ocpCnt = br_reg.ocpCnt + 1'b1;
    else if (!limitActive)
      br_next.ocpCnt = '0;
    if (br_reg.ocpCnt >= dhb_pkg::CNT_W'(dhb_pkg::OCP_CYCLES))
      br_next.overcurrent_shutdown = 1'b1;
    // blanking counts only once the drive pattern is on the pins, so the
    // dead-time cannot eat into the minimum on-time
    if (br_reg.blankCnt != '0 && br_reg.gate ==
        (directionIn ? dhb_pkg::GATE_AFWD : dhb_pkg::GATE_BFWD))
      br_next.blankCnt = br_reg.blankCnt - 1'b1;
    case (br_reg.state)
      dhb_pkg::DHB_DRIVE: begin
        if (!driveOk)
          br_next.state = decayFast ? dhb_pkg::DHB_COAST
                                    : dhb_pkg::DHB_BRAKE;
        else if (chopTrip && br_reg.blankCnt == '0)
          br_next.state = decayFast ? dhb_pkg::DHB_FAST
                                    : dhb_pkg::DHB_SLOW;
      end
      dhb_pkg::DHB_FAST, dhb_pkg::DHB_SLOW: begin
        if (!driveOk)
          br_next.state = decayFast ? dhb_pkg::DHB_COAST
                                    : dhb_pkg::DHB_BRAKE;
        else if (pwmStart) begin
          br_next.state    = dhb_pkg::DHB_DRIVE;
          br_next.blankCnt = dhb_pkg::CNT_W'(dhb_pkg::BLANK_CYCLES);
        end
      end
      dhb_pkg::DHB_OCP: br_next.state = dhb_pkg::DHB_OCP;
      default: begin
        if (driveOk) begin
          br_next.state    = dhb_pkg::DHB_DRIVE;
          br_next.blankCnt = dhb_pkg::CNT_W'(dhb_pkg::BLANK_CYCLES);
        end else
          br_next.state = decayFast ? dhb_pkg::DHB_COAST
                                    : dhb_pkg::DHB_BRAKE;
      end
    endcase
    if (br_reg.overcurrent_shutdown)
      br_next.state = dhb_pkg::DHB_OCP;
    // wanted switches for the state
    case (br_reg.state)
      dhb_pkg::DHB_DRIVE:
        want = directionIn ? dhb_pkg::GATE_AFWD : dhb_pkg::GATE_BFWD;
      dhb_pkg::DHB_FAST:
        // reverse until current dies, then all off
        want = currentZero ? dhb_pkg::GATE_OFF
             : (directionIn ? dhb_pkg::GATE_BFWD
                            : dhb_pkg::GATE_AFWD);
      dhb_pkg::DHB_SLOW:  want = dhb_pkg::GATE_BRAKE;
      dhb_pkg::DHB_BRAKE: want = dhb_pkg::GATE_BRAKE;
      dhb_pkg::DHB_COAST:
        want = currentZero ? dhb_pkg::GATE_OFF
             : (directionIn ? dhb_pkg::GATE_BFWD
                            : dhb_pkg::GATE_AFWD);
      default: want = dhb_pkg::GATE_OFF;
    endcase
    // dead-time: pass through all-off before any new pattern
    if (want != br_reg.gate && br_reg.gate != dhb_pkg::GATE_OFF) begin
      br_next.gate    = dhb_pkg::GATE_OFF;
      // the first all-off cycle already counts towards the dead-time
      br_next.deadCnt = dhb_pkg::CNT_W'(dhb_pkg::DEAD_CYCLES - 1);
    end else if (br_reg.deadCnt != '0)
      br_next.deadCnt = br_reg.deadCnt - 1'b1;
    else
      br_next.gate = want;
    if (!run) begin
      br_next       = '0;
      br_next.overcurrent_shutdown   = br_reg.overcurrent_shutdown;
      br_next.state = br_reg.overcurrent_shutdown ? dhb_pkg::DHB_OCP : dhb_pkg::DHB_IDLE;
    end
  end

  // one register for the whole bridge; ocp cleared only by reset
  always_ff @(posedge clock) begin
    if (!rst_b)
      br_reg <= '0;
    else
      br_reg <= br_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin view and reference level
  always_comb begin
    gateDrive  = br_reg.gate;
    outA       = br_reg.gate[3];
    outB       = br_reg.gate[1];
    outAOe     = br_reg.gate[3] | br_reg.gate[2]; // z when both off
    outBOe     = br_reg.gate[1] | br_reg.gate[0];
    ocpLatched = br_reg.overcurrent_shutdown;
    case (currentScale)
      dhb_pkg::SCALE_FULL: refLevel = dhb_pkg::LEVEL_FULL;
      dhb_pkg::SCALE_71:   refLevel = dhb_pkg::LEVEL_71;
      dhb_pkg::SCALE_38:   refLevel = dhb_pkg::LEVEL_38;
      default:             refLevel = dhb_pkg::LEVEL_ZERO;
    endcase
  end

  // high and low of a leg never together
  legShoot_a: assert property (@(posedge clock) disable iff (!rst_b)
    !(gateDrive[3] && gateDrive[2]) && !(gateDrive[1] && gateDrive[0]))
    else $error("leg shoot-through");
  ocpHold_a: assert property (@(posedge clock) disable iff (!rst_b)
    ocpLatched |=> ocpLatched) else $error("ocp latch lost");
  ocpOff_a: assert property (@(posedge clock) disable iff (!rst_b)
    ocpLatched |-> ##2 gateDrive == dhb_pkg::GATE_OFF)
    else $error("ocp bridge driving");
  blankIgn_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(br_reg.state == dhb_pkg::DHB_DRIVE) && run && !ocpLatched
      |-> (br_reg.state == dhb_pkg::DHB_DRIVE || !driveOk
           || !run || ocpLatched)[*8])
    else $error("chop inside blanking");
  slowLow_a: assert property (@(posedge clock) disable iff (!rst_b)
    br_reg.state == dhb_pkg::DHB_SLOW && run
      && br_next.state == dhb_pkg::DHB_SLOW |-> ##[0:3]
      gateDrive == dhb_pkg::GATE_BRAKE || br_reg.state != dhb_pkg::DHB_SLOW)
    else $error("slow decay not braking");
  chopCov_c: cover property (@(posedge clock) disable iff (!rst_b)
    br_reg.state == dhb_pkg::DHB_DRIVE ##1 br_reg.state == dhb_pkg::DHB_FAST);

endmodule : dhb_bridge

//--- hw/dhb_top.sv
// dual h-bridge motor control logic with chopping and protection
// assumes a 10 MHz clock, pins synchronous to it, analog flags as levels
// Behaviour
// - enabled: direction sets which output is high
// - disabled: decay low brakes, high floats
// - one decay input for both bridges
// - chop trip stops drive until next cycle
// - chopping cycle runs at 50 kHz
// - amplified sense over reference is trip
// - scale bits pick 100/71/38 percent or off
// - fast decay reverses then all off
// - slow decay turns both low sides on
// - disable in fast decay coasts after zero
// - disable in slow decay brakes, stays on
// - ignore sense for 3.75 us blanking
// - blanking is minimum chop on-time
// - reset clears logic and disables bridges
// - sleep disables bridges and stops clocks
// - persistent limit shuts bridge, fault low
// - overcurrent latched until reset
// - overcurrent independent of chopping sense
// - over-temperature disables, auto recovers, fault low
// - undervoltage holds everything in reset
module dhb_top (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // host control pins
  input  wire logic       reset_n,
  input  wire logic       low_power_request_n,
  input  wire logic       decayFast,
  input  wire logic [1:0] direction_in,
  input  wire logic [1:0] bridge_enable_in,
  input  wire logic [1:0] current_scale_hi,
  input  wire logic [1:0] current_scale_lo,
  // analog indications per bridge
  input  wire logic [1:0] chopTrip,
  input  wire logic [1:0] currentZero,
  input  wire logic [1:0] limitActive,
  // supply and die indications
  input  wire logic       thermalShutdown,
  input  wire logic       undervoltageLockout,
  // bridge pins and gates
  output logic [1:0]      bridge_out_a,
  output logic [1:0]      bridge_out_b,
  output logic [1:0]      bridgeOutAOe,
  output logic [1:0]      bridgeOutBOe,
  output logic [7:0]      gateDrive,
  output logic [13:0]     refLevel,
  // status
  output logic            fault_flag_n_o,
  output logic            fault_flag_n_oe,
  output logic            auxRegulatorOn,
  output logic            pwmStart
);

  typedef struct packed {
    logic [dhb_pkg::CNT_W-1:0] pwmCnt;
    logic                      pwmTick;
    logic                      awake;
    logic                      faultLow;
  } dhb_top_t;

  dhb_top_t top_reg;
  dhb_top_t top_next;
  logic       run;
  logic       blockRst_b;
  logic [1:0] ocpLatched;

  ////////////////////////////////////////////////////////////////////////////
  // bridge logic reset: pin reset, chip reset and undervoltage
  // undervoltage is the only way to clear a latched overcurrent besides reset
  always_comb begin
    blockRst_b = rst_b && reset_n && !undervoltageLockout;
    run        = low_power_request_n && !thermalShutdown;
  end

  ////////////////////////////////////////////////////////////////////////////
  // chopping timebase and fault output
  always_comb begin
    top_next         = top_reg;
    top_next.pwmTick = 1'b0;
    top_next.awake   = low_power_request_n;
    // clocks stop in sleep: the divider freezes at zero
    if (!low_power_request_n)
      top_next.pwmCnt = '0;
    else if (top_reg.pwmCnt ==
             dhb_pkg::CNT_W'(dhb_pkg::PWM_CYCLES - 1)) begin
      top_next.pwmCnt  = '0;
      top_next.pwmTick = 1'b1;
    end else
      top_next.pwmCnt = top_reg.pwmCnt + 1'b1;
    top_next.faultLow = thermalShutdown || (|ocpLatched);
  end

  always_ff @(posedge clock) begin
    if (!blockRst_b)
      top_reg <= '0;
    else
      top_reg <= top_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // two identical bridges
  for (genvar i = 0; i < 2; i++) begin : gBridge
    dhb_bridge uBridge (
      .clock          (clock),
      .rst_b          (blockRst_b),
      .run            (run),
      .pwmStart       (top_reg.pwmTick),
      .decayFast      (decayFast),
      .directionIn    (direction_in[i]),
      .bridgeEnableIn (bridge_enable_in[i]),
      .currentScale   ({current_scale_hi[i], current_scale_lo[i]}),
      .chopTrip       (chopTrip[i]),
      .currentZero    (currentZero[i]),
      .limitActive    (limitActive[i]),
      .gateDrive      (gateDrive[4*i +: 4]),
      .refLevel       (refLevel[7*i +: 7]),
      .outAOe         (bridgeOutAOe[i]),
      .outBOe         (bridgeOutBOe[i]),
      .outA           (bridge_out_a[i]),
      .outB           (bridge_out_b[i]),
      .ocpLatched     (ocpLatched[i])
    );
  end

  // open-drain fault: only ever pulls low
  always_comb begin
    fault_flag_n_o  = 1'b0;
    fault_flag_n_oe = top_reg.faultLow;
    auxRegulatorOn  = top_reg.awake;
    pwmStart        = top_reg.pwmTick;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  pwmPeriod_a: assert property (@(posedge clock) disable iff (!blockRst_b)
    pwmStart |=> !pwmStart [*8])
    else $error("chop tick too close");
  faultTsd_a: assert property (@(posedge clock) disable iff (!blockRst_b)
    thermalShutdown |=> fault_flag_n_oe) else $error("no fault on tsd");
  sleepOff_a: assert property (@(posedge clock) disable iff (!blockRst_b)
    !low_power_request_n [*2] |-> gateDrive == 8'h00 && !pwmStart)
    else $error("active in sleep");
  tsdOff_a: assert property (@(posedge clock) disable iff (!blockRst_b)
    thermalShutdown [*2] |-> gateDrive == 8'h00)
    else $error("driving in tsd");
  rstOff_a: assert property (@(posedge clock)
    !reset_n |=> gateDrive == 8'h00 && fault_flag_n_oe == 1'b0)
    else $error("not reset");
  fwdDrive_a: assert property (@(posedge clock) disable iff (!blockRst_b)
    gBridge[0].uBridge.br_reg.state == dhb_pkg::DHB_DRIVE
      && $past(gBridge[0].uBridge.br_reg.state) == dhb_pkg::DHB_DRIVE
      && gateDrive[3:0] != 4'h0 |-> gateDrive[3:0] ==
      (direction_in[0] ? dhb_pkg::GATE_AFWD : dhb_pkg::GATE_BFWD)
      || $changed(direction_in[0]) || $past(direction_in[0]) != direction_in[0])
    else $error("wrong drive direction");
  ocpFault_a: assert property (@(posedge clock) disable iff (!blockRst_b)
    |ocpLatched |=> !fault_flag_n_o && fault_flag_n_oe)
    else $error("ocp without fault");
  scaleOff_a: assert property (@(posedge clock) disable iff (!blockRst_b)
    current_scale_hi[0] && current_scale_lo[0] |-> refLevel[6:0] == 7'h00)
    else $error("scale off not zero");
  brakeCov_c: cover property (@(posedge clock) disable iff (!blockRst_b)
    !bridge_enable_in[0] && !decayFast ##3 gateDrive[3:0] == 4'h5);
  coastCov_c: cover property (@(posedge clock) disable iff (!blockRst_b)
    !bridge_enable_in[1] && decayFast ##3 !bridgeOutAOe[1]);
  ocpCov_c: cover property (@(posedge clock) disable iff (!blockRst_b)
    $rose(|ocpLatched));

endmodule : dhb_top

//--- test/dhb_host_model.sv
// host model: drives the parallel control pins of the motor logic
// assumes pins move at the falling edge of the shared clock
module dhb_host_model (
  // clock
  input  wire logic       clock,
  // pins towards the device
  output logic            reset_n,
  output logic            low_power_request_n,
  output logic            decayFast,
  output logic [1:0]      direction_in,
  output logic [1:0]      bridge_enable_in,
  output logic [1:0]      current_scale_hi,
  output logic [1:0]      current_scale_lo
);
  timeunit 1ns;
  timeprecision 1ns;
  int sinceEn = 1000;
  ////////////////////////////////////////////////////////////////////////////
  // idle pins: awake, out of reset, bridges off
  initial begin
    reset_n = 1'b1;
    low_power_request_n = 1'b1;
    decayFast = 1'b0;
    direction_in = 2'h0;
    bridge_enable_in = 2'h0;
    current_scale_hi = 2'h0;
    current_scale_lo = 2'h0;
  end
  // cycles since the enable pins last moved
  always @(posedge clock) begin
    sinceEn <= sinceEn + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // enable edges kept 50 cycles apart: external pwm never above 100 kHz
  task automatic pins(input logic dec, input logic [1:0] dir, en, hi, lo);
    while (en !== bridge_enable_in && sinceEn < 50) @(negedge clock);
    @(negedge clock);
    if (en !== bridge_enable_in) sinceEn = 0;
    decayFast = dec;
    direction_in = dir;
    bridge_enable_in = en;
    current_scale_hi = hi;
    current_scale_lo = lo;
  endtask : pins
  // sleep or wake; after wake the driver needs about 1 ms to settle
  task automatic lowPower(input logic awake);
    @(negedge clock);
    low_power_request_n = awake;
    if (awake) repeat (10000) @(negedge clock);
  endtask : lowPower
  // host reset pulse of n cycles
  task automatic resetPulse(input int n);
    @(negedge clock);
    reset_n = 1'b0;
    repeat (n) @(negedge clock);
    reset_n = 1'b1;
  endtask : resetPulse
endmodule : dhb_host_model

//--- test/tb_top.sv
// self-checking bench for the dual h-bridge logic
// assumes a 10 MHz clock; analog flags are driven here, pins by the host
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] chopTrip = 2'h0, currentZero = 2'h0, limitActive = 2'h0;
  logic thermalShutdown = 1'b0, undervoltageLockout = 1'b0;
  logic resetN, lowPowerN, decayFast;
  logic [1:0] dirIn, enIn, scaleHi, scaleLo, outA, outB, oeA, oeB;
  logic [7:0] gateDrive;
  logic [13:0] refLevel;
  logic faultO, faultOe, auxOn, pwmStart, faultPin;
  int err_total = 0, compares = 0, cyc = 0;
  // open-drain fault line with pull-up
  assign faultPin = faultOe ? faultO : 1'b1;
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  dhb_host_model host_u (.clock(clock), .reset_n(resetN),
    .low_power_request_n(lowPowerN), .decayFast(decayFast),
    .direction_in(dirIn), .bridge_enable_in(enIn),
    .current_scale_hi(scaleHi), .current_scale_lo(scaleLo));
  dhb_top dut_u (.clock(clock), .rst_b(rst_b), .reset_n(resetN),
    .low_power_request_n(lowPowerN), .decayFast(decayFast),
    .direction_in(dirIn), .bridge_enable_in(enIn),
    .current_scale_hi(scaleHi), .current_scale_lo(scaleLo),
    .chopTrip(chopTrip), .currentZero(currentZero),
    .limitActive(limitActive), .thermalShutdown(thermalShutdown),
    .undervoltageLockout(undervoltageLockout), .bridge_out_a(outA),
    .bridge_out_b(outB), .bridgeOutAOe(oeA), .bridgeOutBOe(oeB),
    .gateDrive(gateDrive), .refLevel(refLevel), .fault_flag_n_o(faultO),
    .fault_flag_n_oe(faultOe), .auxRegulatorOn(auxOn), .pwmStart(pwmStart));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // hang guard: whole run needs well under 20000 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [13:0] exp, got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // wait, bounded, for a gate pattern on bridge b, then judge it
  task automatic waitGate(input int b, input logic [3:0] exp, input int n);
    repeat (n) if (gateDrive[4*b+:4] !== exp) @(negedge clock);
    chk($sformatf("gate%0d", b), exp, gateDrive[4*b+:4]);
  endtask : waitGate
  task automatic run2; // bridge 0 forward, bridge 1 reverse
    host_u.pins(decayFast, 2'h1, 2'h3, 2'h0, 2'h0);
    waitGate(0, 4'h9, 12);
    waitGate(1, 4'h6, 12);
  endtask : run2
  ////////////////////////////////////////////////////////////////////////////
  task automatic tDrive;
    logic [6:0] lv [4];
    lv = '{dhb_pkg::LEVEL_FULL, dhb_pkg::LEVEL_71, dhb_pkg::LEVEL_38,
           dhb_pkg::LEVEL_ZERO};
    run2();
    chk("pins", {4'h0, 2'h1, 2'h2, 2'h3, 2'h3}, {outA, outB, oeA, oeB});
    for (int k = 0; k < 4; k++) begin
      // bridge 0 gets scale code k, bridge 1 gets code 3-k
      host_u.pins(1'b0, 2'h1, 2'h3, {~k[1], k[1]}, {~k[0], k[0]});
      @(negedge clock);
      chk("ref", {lv[3-k], lv[k]}, refLevel);
    end
    $display("test drive done");
  endtask : tDrive
  task automatic tDisable;
    host_u.pins(1'b1, 2'h1, 2'h3, 2'h0, 2'h0);
    run2();
    host_u.pins(1'b1, 2'h1, 2'h0, 2'h0, 2'h0);
    waitGate(0, 4'h6, 8);
    waitGate(1, 4'h9, 8);
    currentZero = 2'h3;
    waitGate(0, 4'h0, 8);
    chk("float oe", 4'h0, {oeA, oeB});
    currentZero = 2'h0;
    run2();
    host_u.pins(1'b0, 2'h1, 2'h0, 2'h0, 2'h0);
    waitGate(0, 4'h5, 8);
    waitGate(1, 4'h5, 8);
    currentZero = 2'h3;
    repeat (20) @(negedge clock);
    chk("brake", 8'h55, gateDrive);
    chk("low pins", 8'h0f, {outA, outB, oeA, oeB});
    currentZero = 2'h0;
    $display("test disable done");
  endtask : tDisable
  ////////////////////////////////////////////////////////////////////////////
  task automatic tChop;
    int held;
    for (int d = 0; d < 2; d++) begin
      host_u.pins(d[0], 2'h1, 2'h0, 2'h0, 2'h0);
      chopTrip = 2'h1;
      // start just after a chop tick so no tick lands in the decay entry
      repeat (50) @(negedge clock);
      repeat (210) if (pwmStart !== 1'b1) @(negedge clock);
      host_u.pins(d[0], 2'h1, 2'h1, 2'h0, 2'h0);
      waitGate(0, 4'h9, 12);
      held = 0;
      repeat (30) begin
        @(negedge clock);
        held += (gateDrive[3:0] === 4'h9);
      end
      chk("blank hold", 14'd30, held);
      waitGate(0, d ? 4'h6 : 4'h5, 15);
      chopTrip = 2'h0;
      repeat (210) if (pwmStart !== 1'b1) @(negedge clock);
      chk("decay held", d ? 4'h6 : 4'h5, gateDrive[3:0]);
      waitGate(0, 4'h9, 10);
    end
    $display("test chop done");
  endtask : tChop
  task automatic tProtect;
    run2();
    limitActive = 2'h1;
    repeat (35) @(negedge clock);
    limitActive = 2'h0;
    chk("ocp", {4'h6, 4'h0, 1'b0}, {gateDrive, faultPin});
    repeat (50) @(negedge clock);
    chk("latched", {4'h0, 1'b0}, {gateDrive[3:0], faultPin});
    host_u.resetPulse(2);
    chk("in reset", 12'h0, {gateDrive, oeA, oeB});
    waitGate(0, 4'h9, 12);
    chk("fault off", 1'b1, faultPin);
    thermalShutdown = 1'b1;
    waitGate(0, 4'h0, 5);
    chk("hot", {4'h0, 1'b0}, {gateDrive[7:4], faultPin});
    thermalShutdown = 1'b0;
    waitGate(0, 4'h9, 12);
    chk("cool", 1'b1, faultPin);
    undervoltageLockout = 1'b1;
    repeat (2) @(negedge clock);
    chk("undervoltage_lockout", 12'h0, {gateDrive, oeA, oeB});
    undervoltageLockout = 1'b0;
    waitGate(0, 4'h9, 12);
    $display("test protect done");
  endtask : tProtect
  task automatic tSleep;
    int gap, pulses;
    run2();
    repeat (210) if (pwmStart !== 1'b1) @(negedge clock);
    gap = 0;
    do begin
      @(negedge clock);
      gap++;
    end while (pwmStart !== 1'b1 && gap < 300);
    chk("pwm period", 14'd200, gap);
    host_u.lowPower(1'b0);
    repeat (3) @(negedge clock);
    chk("asleep", 9'h0, {gateDrive, auxOn});
    pulses = 0;
    repeat (250) begin
      @(negedge clock);
      pulses += (pwmStart === 1'b1);
    end
    chk("clock stopped", 14'd0, pulses);
    host_u.lowPower(1'b1);
    waitGate(0, 4'h9, 12);
    chk("aux on", 1'b1, auxOn);
    $display("test sleep done");
  endtask : tSleep
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    tDrive();
    tDisable();
    tChop();
    tProtect();
    tSleep();
    end_of_test();
  end
endmodule : tb_top
